// ### src/twp_core.sv
// Protect and protection-query command handling with Wishbone registers
//
// Our own choices: the Wishbone register port and the address map.
`timescale 1ns/10ps

module twp_core
    import twp_pkg::*;
#(
    parameter int PROG_LEN = PROG_CYCLES
) (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    // Reply towards the transmitter
    output twp_resp_t        resp_o,
    output logic             nv_busy_o
);

    // Controller state and the captured command frame
    twp_state_t            state_q;
    twp_cmd_t              cmd_q;
    // Serial identifier this tag answers to
    logic [63:0]           own_sid_q;
    // Identified state, success flag and the per-byte tables
    logic                  ident_q;
    logic                  wr_ok_q;
    logic [MEM_BYTES-1:0]  prot_q;
    logic [MEM_BYTES-1:0]  mark_q;
    logic [31:0]           prog_cnt_q;
    logic [4:0]            prog_idx_q;
    logic                  ack_q;
    logic [31:0]           dat_q;
    twp_resp_t             resp_q;
    twp_kind_t             last_kind_q;
    logic [15:0]           last_crc_q;
    logic                  last_valid_q;

    logic        bus_wr;
    logic        ctrl_wr;
    logic        start;
    // Decoded command terms, all from flops of this clock
    logic        sid_match;
    logic        in_range;
    logic [4:0]  idx;
    logic        eval_prot;
    logic        eval_query;
    logic        query_hit;

    // Merge written byte lanes into an old word
    function automatic logic [31:0] lanes(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  sel);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return r;
    endfunction

    // Map a reply kind to its fixed CRC
    function automatic logic [15:0] crc_of(input twp_kind_t k);
        logic [15:0] c;
        case (k)
            RK_ACK, RK_NACK: c = CRC_ACK;
            RK_POS_OK:       c = CRC_POS_OK;
            RK_ERR_OK:       c = CRC_ERR_OK;
            default:         c = CRC_ERR;
        endcase
        return c;
    endfunction

    // Bus decode; single cycle strobes only in the request's first cycle
    assign bus_wr  = cyc_i && stb_i && we_i && !ack_q;
    assign ctrl_wr = bus_wr && (adr_i == OFF_CTRL);
    // Commands are ignored while the protection bit is being programmed
    assign start   = ctrl_wr && sel_i[0] && dat_i[CTRL_START_BIT]
                     && (state_q == ST_IDLE);

    // Command evaluation terms
    // Full 64-bit compare; a half-written serial simply mismatches
    assign sid_match  = (cmd_q.sid == own_sid_q);
    assign in_range   = (cmd_q.addr < 8'(MEM_BYTES));
    assign idx        = cmd_q.addr[4:0];
    assign eval_prot  = (state_q == ST_EVAL) && cmd_q.crc_ok
                        && (cmd_q.op == OP_PROTECT);
    assign eval_query = (state_q == ST_EVAL) && cmd_q.crc_ok
                        && (cmd_q.op == OP_QUERY);
    assign query_hit  = eval_query && sid_match;

    // Wishbone acknowledge, one cycle after the strobe.
    // The !ack_q term keeps a held request from being taken twice;
    // the master may present its next request in the cycle right after the ack.
    // Every offset is answered, mapped or not, so a bad address
    // never hangs the bus.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= cyc_i && stb_i && !ack_q;
        end
    end

    // Read data; unmapped offsets read zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_q <= RST_WORD;
        end else if (cyc_i && stb_i && !we_i && !ack_q) begin
            case (adr_i)
                OFF_CTRL:   dat_q <= {8'h00, cmd_q.addr, cmd_q.op,
                                      6'h00, cmd_q.crc_ok, 1'b0};
                OFF_SID_LO: dat_q <= cmd_q.sid[31:0];
                OFF_SID_HI: dat_q <= cmd_q.sid[63:32];
                OFF_OWN_LO: dat_q <= own_sid_q[31:0];
                OFF_OWN_HI: dat_q <= own_sid_q[63:32];
                OFF_STATUS: dat_q <= {last_crc_q, REPLY_FILL, 1'b0,
                                      last_valid_q,
                                      state_q == ST_PROG, wr_ok_q,
                                      ident_q, last_kind_q};
                OFF_PROT:   dat_q <= prot_q;
                OFF_MARK:   dat_q <= mark_q;
                default:    dat_q <= RST_WORD;
            endcase
        end
    end

    // Command frame capture from software.
    // Frozen outside idle so a command under evaluation or being
    // programmed cannot be altered halfway; such writes are dropped
    // without any indication, software must poll busy first.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cmd_q <= '0;
        end else if (bus_wr && state_q == ST_IDLE) begin
            case (adr_i)
                OFF_CTRL: begin
                    if (sel_i[0]) begin
                        cmd_q.crc_ok <= dat_i[CTRL_CRC_OK_BIT];
                    end
                    if (sel_i[1]) begin
                        cmd_q.op <= dat_i[CTRL_OP_LSB +: 8];
                    end
                    if (sel_i[2]) begin
                        cmd_q.addr <= dat_i[CTRL_ADDR_LSB +: 8];
                    end
                end
                OFF_SID_LO: cmd_q.sid[31:0] <= lanes(cmd_q.sid[31:0],
                                                     dat_i, sel_i);
                OFF_SID_HI: cmd_q.sid[63:32] <= lanes(cmd_q.sid[63:32],
                                                      dat_i, sel_i);
                default: ;
            endcase
        end
    end

    // Stored serial identifier of this tag
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            own_sid_q <= '0;
        end else if (bus_wr && adr_i == OFF_OWN_LO) begin
            own_sid_q[31:0] <= lanes(own_sid_q[31:0], dat_i, sel_i);
        end else if (bus_wr && adr_i == OFF_OWN_HI) begin
            own_sid_q[63:32] <= lanes(own_sid_q[63:32], dat_i, sel_i);
        end
    end

    // Controller: evaluate one cycle, then program if needed.
    // Evaluation takes exactly one cycle so any reply always comes
    // two edges after the start write, whatever its kind; silent outcomes give none.
    // Programming holds the controller for the whole nonvolatile
    // write time; a real tag would lose the bit if the field dropped
    // earlier, which is why the reader must keep the carrier up.
    // The stored protection bit is only set once the timer expires.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= ST_IDLE;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (start) begin
                        state_q <= ST_EVAL;
                    end
                end
                ST_EVAL: begin
                    if (eval_prot && ident_q && sid_match
                        && in_range && mark_q[idx]) begin
                        state_q <= ST_PROG;
                    end else begin
                        state_q <= ST_IDLE;
                    end
                end
                ST_PROG: begin
                    if (prog_cnt_q == 32'(PROG_LEN - 1)) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // Programming timer and target byte.
    // The index is latched while not programming, so a later
    // command frame cannot redirect a write that is in flight.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prog_cnt_q <= '0;
            prog_idx_q <= '0;
        end else if (state_q == ST_PROG) begin
            prog_cnt_q <= prog_cnt_q + 32'h0000_0001;
        end else begin
            prog_cnt_q <= '0;
            prog_idx_q <= idx;
        end
    end

    // Protection bits; a bit becomes set only when programming ends
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prot_q <= '0;
        end else if (state_q == ST_PROG
                     && prog_cnt_q == 32'(PROG_LEN - 1)) begin
            prot_q[prog_idx_q] <= 1'b1;
        end
    end

    // Protectable tracking; a new mark wins over a clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mark_q <= '0;
        end else if (query_hit && in_range) begin
            mark_q[idx] <= 1'b1;
        end else if (ctrl_wr && sel_i[3] && dat_i[CTRL_CLR_ID]) begin
            mark_q <= '0;
        end
    end

    // Identified state; setting wins over clearing
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ident_q <= 1'b0;
        end else if (query_hit) begin
            ident_q <= 1'b1;
        end else if (ctrl_wr && sel_i[3] && dat_i[CTRL_SET_ID]) begin
            ident_q <= 1'b1;
        end else if (ctrl_wr && sel_i[3] && dat_i[CTRL_CLR_ID]) begin
            ident_q <= 1'b0;
        end
    end

    // Last-program-success flag from write access results
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_ok_q <= RST_WR_OK;
        end else if (ctrl_wr && sel_i[3] && dat_i[CTRL_WR_DONE]) begin
            wr_ok_q <= dat_i[CTRL_WR_OK];
        end
    end

    // Reply generation, one pulse in the cycle after evaluation.
    // Kind and CRC hold between pulses; only valid returns low.
    // The data byte is a fixed fill, since the reader keys on CRC.
    // Protect replies need both identified state and a serial match;
    // without them the tag stays quiet rather than refusing.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            resp_q <= '0;
        end else begin
            resp_q.valid <= 1'b0;
            resp_q.data  <= REPLY_FILL;
            if (eval_prot && ident_q && sid_match) begin
                resp_q.valid <= 1'b1;
                if (in_range && mark_q[idx]) begin
                    resp_q.kind <= RK_ACK;
                    resp_q.crc  <= crc_of(RK_ACK);
                end else begin
                    resp_q.kind <= RK_NACK;
                    resp_q.crc  <= crc_of(RK_NACK);
                end
            end else if (query_hit) begin
                resp_q.valid <= 1'b1;
                // Out-of-range queries read as unprotected
                if (in_range && prot_q[idx]) begin
                    // Protected byte
                    resp_q.kind <= wr_ok_q ? RK_ERR_OK : RK_ERR_NOK;
                    resp_q.crc  <= crc_of(wr_ok_q ? RK_ERR_OK
                                                  : RK_ERR_NOK);
                end else begin
                    // Unprotected byte
                    resp_q.kind <= wr_ok_q ? RK_POS_OK : RK_NACK;
                    resp_q.crc  <= crc_of(wr_ok_q ? RK_POS_OK
                                                  : RK_NACK);
                end
            end
            // Anything else stays silent
        end
    end

    // Last reply kept for software
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            last_kind_q  <= RK_ACK;
            last_crc_q   <= '0;
            last_valid_q <= 1'b0;
        end else if (start) begin
            last_valid_q <= 1'b0;
        end else if (resp_q.valid) begin
            last_kind_q  <= resp_q.kind;
            last_crc_q   <= resp_q.crc;
            last_valid_q <= 1'b1;
        end
    end

    // Outputs straight from flops; busy is the one-hot program bit
    assign ack_o     = ack_q;
    assign dat_o     = dat_q;
    assign resp_o    = resp_q;
    assign nv_busy_o = state_q[2];

endmodule

// ### shared/twp_pkg.sv
// Constants, types and register map for the tag protection command block
package twp_pkg;

    // Register byte offsets
    localparam logic [7:0] OFF_CTRL   = 8'h00;
    localparam logic [7:0] OFF_SID_LO = 8'h04;
    localparam logic [7:0] OFF_SID_HI = 8'h08;
    localparam logic [7:0] OFF_OWN_LO = 8'h0C;
    localparam logic [7:0] OFF_OWN_HI = 8'h10;
    localparam logic [7:0] OFF_STATUS = 8'h14;
    localparam logic [7:0] OFF_PROT   = 8'h18;
    localparam logic [7:0] OFF_MARK   = 8'h1C;

    // Control register fields (write side)
    localparam int CTRL_START_BIT  = 0;
    localparam int CTRL_CRC_OK_BIT = 1;
    localparam int CTRL_OP_LSB     = 8;
    localparam int CTRL_ADDR_LSB   = 16;
    localparam int CTRL_WR_DONE    = 24;
    localparam int CTRL_WR_OK      = 25;
    localparam int CTRL_SET_ID     = 26;
    localparam int CTRL_CLR_ID     = 27;

    // Status register fields (read side)
    localparam int ST_KIND_LSB   = 0;
    localparam int ST_DATA_LSB   = 8;
    localparam int ST_CRC_LSB    = 16;
    localparam int ST_IDENT_BIT  = 3;
    localparam int ST_WROK_BIT   = 4;
    localparam int ST_BUSY_BIT   = 5;
    localparam int ST_VALID_BIT  = 6;

    // Command codes
    localparam logic [7:0] OP_PROTECT = 8'h0F;
    localparam logic [7:0] OP_QUERY   = 8'h11;

    // Protectable byte space
    localparam int MEM_BYTES = 32;

    // Fixed short-reply CRC values and don't-care data byte
    localparam logic [15:0] CRC_ACK    = 16'h1E0F;
    localparam logic [15:0] CRC_POS_OK = 16'h0E2E;
    localparam logic [15:0] CRC_ERR    = 16'h00FF;
    localparam logic [15:0] CRC_ERR_OK = 16'h10DE;
    localparam logic [7:0]  REPLY_FILL = 8'h00;

    // Reset values
    localparam logic [31:0] RST_WORD  = 32'h0000_0000;
    localparam logic        RST_WR_OK = 1'b0;

    // Nonvolatile programming time
    localparam int EE_WRITE_NS = 13300000;
    localparam int CLK_NS      = 20;
    localparam int PROG_CYCLES = (EE_WRITE_NS + CLK_NS - 1) / CLK_NS;

    // Reply kinds
    typedef enum logic [2:0] {
        RK_ACK     = 3'h0,
        RK_NACK    = 3'h1,
        RK_POS_OK  = 3'h2,
        RK_ERR     = 3'h3,
        RK_ERR_OK  = 3'h4,
        RK_ERR_NOK = 3'h5
    } twp_kind_t;

    // Controller states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_EVAL = 3'b010,
        ST_PROG = 3'b100
    } twp_state_t;

    // One decoded command frame
    typedef struct packed {
        logic [7:0]  op;
        logic [7:0]  addr;
        logic        crc_ok;
        logic [63:0] sid;
    } twp_cmd_t;

    // One short reply
    typedef struct packed {
        logic        valid;
        twp_kind_t   kind;
        logic [7:0]  data;
        logic [15:0] crc;
    } twp_resp_t;

endpackage

// ### testbench/twp_core_assertions.sv
// Port-level assertions for the protect and query block
`timescale 1ns/10ps

module twp_core_chk
    import twp_pkg::*;
#(
    parameter int PROG_LEN = 8
) (
    // Clock and reset
    input wire logic        clk_i,
    input wire logic        rst_i,
    // Register bus
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic        we_i,
    input wire logic [7:0]  adr_i,
    input wire logic [3:0]  sel_i,
    input wire logic [31:0] dat_i,
    input wire logic        ack_o,
    // Reply side
    input twp_resp_t        resp_o,
    input wire logic        nv_busy_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // Command launch write as seen on the bus, all four lanes enabled; the design's idle check is not seen here
    logic start_w;
    assign start_w = cyc_i & stb_i & we_i & !ack_o & (adr_i == OFF_CTRL)
                   & (sel_i == 4'hF) & dat_i[CTRL_START_BIT];

    // Busy length, restarts whenever busy is low
    int busy_cnt_q;
    always_ff @(posedge clk_i) begin
        if (rst_i || !nv_busy_o) busy_cnt_q <= 0;
        else busy_cnt_q <= busy_cnt_q + 1;
    end

    crc_ack_a: assert property (resp_o.valid && (resp_o.kind == RK_ACK
        || resp_o.kind == RK_NACK) |-> resp_o.crc == CRC_ACK)
        else $error("wrong crc on acknowledge reply");
    crc_posok_a: assert property (resp_o.valid &&
        resp_o.kind == RK_POS_OK |-> resp_o.crc == CRC_POS_OK)
        else $error("wrong crc on positive-ok reply");
    crc_err_a: assert property (resp_o.valid && (resp_o.kind == RK_ERR
        || resp_o.kind == RK_ERR_NOK) |-> resp_o.crc == CRC_ERR)
        else $error("wrong crc on error reply");
    crc_errok_a: assert property (resp_o.valid &&
        resp_o.kind == RK_ERR_OK |-> resp_o.crc == CRC_ERR_OK)
        else $error("wrong crc on error-ok reply");
    fill_byte_a: assert property (resp_o.valid |->
        resp_o.data == REPLY_FILL) else $error("reply data byte not fill");
    bad_crc_a: assert property (start_w && !dat_i[CTRL_CRC_OK_BIT]
        |=> !resp_o.valid [*3]) else $error("reply to corrupt frame");
    bad_op_a: assert property (start_w && dat_i[CTRL_OP_LSB +: 8]
        != OP_PROTECT && dat_i[CTRL_OP_LSB +: 8] != OP_QUERY
        |=> !resp_o.valid [*3]) else $error("reply to foreign command");
    reply_cause_a: assert property (resp_o.valid |->
        $past(start_w, 2)) else $error("reply without command");
    ack_busy_a: assert property (resp_o.valid && resp_o.kind == RK_ACK
        |-> nv_busy_o && !$past(nv_busy_o)) else $error("no programming");
    busy_len_a: assert property ($fell(nv_busy_o) |->
        busy_cnt_q == PROG_LEN) else $error("programming length wrong");
endmodule

bind twp_core twp_core_chk #(.PROG_LEN(PROG_LEN)) u_chk (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .ack_o(ack_o), .resp_o(resp_o), .nv_busy_o(nv_busy_o));

// ### testbench/twp_reader_model.sv
// Reader-side model: counts short replies, keeps only their CRC
`timescale 1ns/10ps

module twp_reader_model
    import twp_pkg::*;
(
    // Clock and reset
    input  wire logic   clk_i,
    input  wire logic   rst_i,
    // Reply seen on the air
    input  twp_resp_t   resp_i,
    // What the reader concluded
    output logic [15:0] crc_o,
    output int          count_o
);
    // Data byte is meaningless, so it is dropped
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            crc_o   <= 16'h0000;
            count_o <= 0;
        end else if (resp_i.valid) begin
            crc_o   <= resp_i.crc;
            count_o <= count_o + 1;
        end
    end
endmodule

// ### testbench/twp_core_tb_top.sv
// Self-checking bench for the protect and protection-query block
`timescale 1ns/10ps

module twp_core_tb_top
    import twp_pkg::*;
;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc_i = 1'b0;
    logic        stb_i = 1'b0;
    logic        we_i  = 1'b0;
    logic [7:0]  adr_i = 8'h00;
    logic [3:0]  sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0000_0000;
    logic [31:0] dat_o;
    logic        ack_o;
    twp_resp_t   resp_o;
    logic        nv_busy_o;
    logic [15:0] rx_crc;
    int          rx_count;
    logic [31:0] rd;
    int          n_errors = 0;
    int          checked  = 0;

    twp_core #(.PROG_LEN(8)) dut (.clk_i(clk_i), .rst_i(rst_i),
        .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
        .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .resp_o(resp_o), .nv_busy_o(nv_busy_o));
    twp_reader_model rdr (.clk_i(clk_i), .rst_i(rst_i), .resp_i(resp_o),
        .crc_o(rx_crc), .count_o(rx_count));

    // 50 MHz clock
    initial begin
        forever #10 clk_i = ~clk_i;
    end

    task automatic chk(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One classic cycle; waits for ack, then releases
    task automatic wb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
        int n;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= wr;
        adr_i <= a;
        dat_i <= d;
        sel_i <= 4'hF;
        for (n = 0; n < 20 && ack_o !== 1'b1; n++) @(posedge clk_i);
        if (n == 20) n_errors++;
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i  <= 1'b0;
    endtask

    // Launch a command, judge the reply, wait out programming
    task automatic cmd(input logic [7:0] op, input logic [7:0] a,
                       input logic ok, input logic due,
                       input twp_kind_t k, input logic [15:0] crc);
        int n0;
        n0 = rx_count;
        wb(1'b1, OFF_CTRL, {8'h00, a, op, 6'h00, ok, 1'b1});
        repeat (4) @(posedge clk_i);
        chk("reply count", 32'(rx_count - n0), 32'(due));
        if (due) begin
            chk("kind", 32'(resp_o.kind), 32'(k));
            chk("crc", 32'(rx_crc), 32'(crc));
        end
        for (n0 = 0; n0 < 40 && nv_busy_o !== 1'b0; n0++)
            @(posedge clk_i);
    endtask

    task automatic t_reset();
        wb(1'b0, OFF_STATUS, 32'h0);
        chk("status", rd, RST_WORD);
        wb(1'b0, 8'h40, 32'h0);
        chk("unmapped", rd, 32'h0000_0000);
        wb(1'b1, OFF_OWN_LO, 32'hA5C3_1234);
        wb(1'b1, OFF_OWN_HI, 32'h0BAD_F00D);
        wb(1'b1, OFF_SID_LO, 32'hA5C3_1234);
        wb(1'b1, OFF_SID_HI, 32'h0BAD_F00D);
    endtask

    task automatic t_gate();
        cmd(OP_PROTECT, 8'h03, 1'b1, 1'b0, RK_ACK, 16'h0);
        cmd(8'h0A, 8'h03, 1'b1, 1'b0, RK_ACK, 16'h0);
        wb(1'b1, OFF_CTRL, 32'h0400_0000);
        cmd(OP_PROTECT, 8'h03, 1'b1, 1'b1, RK_NACK, CRC_ACK);
        cmd(OP_PROTECT, 8'h40, 1'b1, 1'b1, RK_NACK, CRC_ACK);
    endtask

    task automatic t_query_protect();
        cmd(OP_QUERY, 8'h03, 1'b1, 1'b1, RK_NACK, CRC_ACK);
        wb(1'b0, OFF_MARK, 32'h0);
        chk("mark", 32'(rd[3]), 32'h1);
        wb(1'b1, OFF_CTRL, 32'h0300_0000);
        wb(1'b0, OFF_STATUS, 32'h0);
        chk("flag", 32'(rd[ST_WROK_BIT]), 32'h1);
        cmd(OP_QUERY, 8'h03, 1'b1, 1'b1, RK_POS_OK, CRC_POS_OK);
        cmd(OP_PROTECT, 8'h03, 1'b1, 1'b1, RK_ACK, CRC_ACK);
        wb(1'b0, OFF_PROT, 32'h0);
        chk("prot", rd, 32'h0000_0008);
        cmd(OP_QUERY, 8'h03, 1'b1, 1'b1, RK_ERR_OK, CRC_ERR_OK);
        wb(1'b1, OFF_CTRL, 32'h0100_0000);
        cmd(OP_QUERY, 8'h03, 1'b1, 1'b1, RK_ERR_NOK, CRC_ERR);
    endtask

    task automatic t_silent_ident();
        wb(1'b1, OFF_SID_LO, 32'hA5C3_1235);
        cmd(OP_QUERY, 8'h03, 1'b1, 1'b0, RK_ACK, 16'h0);
        wb(1'b1, OFF_SID_LO, 32'hA5C3_1234);
        cmd(OP_QUERY, 8'h03, 1'b0, 1'b0, RK_ACK, 16'h0);
        wb(1'b1, OFF_CTRL, 32'h0800_0000);
        wb(1'b0, OFF_STATUS, 32'h0);
        chk("ident off", 32'(rd[ST_IDENT_BIT]), 32'h0);
        cmd(OP_QUERY, 8'h05, 1'b1, 1'b1, RK_NACK, CRC_ACK);
        wb(1'b0, OFF_STATUS, 32'h0);
        chk("ident on", 32'(rd[ST_IDENT_BIT]), 32'h1);
    endtask

    task automatic tally_and_finish();
        if (n_errors == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Watchdog well beyond the expected run
    initial begin
        repeat (3000) @(posedge clk_i);
        n_errors++;
        tally_and_finish();
    end

    // Main sequence
    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_gate();
        t_query_protect();
        t_silent_ident();
        tally_and_finish();
    end
endmodule
